// *** hw/scs_sync_supervision.sv ***
// sync cycle supervision register bank with axi4-lite slave
// Overview of operation
// - input sync mode: 0,1,2,3,34; default 34
// - supported modes word reads 0xC807
// - minimum cycle time reads 0x000186A0 until a longer output cycle is measured
// - command 1 in either word starts, 0 in both words stops measurement
// - measuring captures maximum observed times
// - new measurement clears previous maxima
// - count missed sync-manager events in dc
// - count late or too early cycles
// - count too short sync0-sync1 spacing
// - sync fault flag for late outputs
// - report sync1 to output delay
// - report sync0 to sync1 maximum spacing
// - report sync0 to input sampling time
// - report sampling to availability time
// - report sync1 to input sampling time
// - output sync mode: 0..3; default 1
// - cycle period in ns, default 1000000
`timescale 1ns/1ns
module scs_sync_supervision
   import scs_pkg::*;
#(
   parameter int STEP_NS = CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [scs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [scs_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sync pins and local events
   input wire logic sync0_pin,
   input wire logic sync1_pin,
   input wire scs_pkg::scs_evt_t evt,
   input wire logic op_state,
   // interrupt
   output logic irq
);
   logic [15:0] out_sync_select;
   logic [15:0] in_sync_select;
   logic [31:0] out_cycle_period;
   logic [31:0] in_cycle_period;
   logic [15:0] out_measure_command;
   logic [15:0] in_measure_command;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [1:0] s0_sync;
   logic [1:0] s1_sync;
   logic s0_prev;
   logic s1_prev;
   logic sync0;
   logic sync1;
   logic [31:0] now_ns;
   logic [31:0] t_sync0;
   logic [31:0] t_sync1;
   logic [31:0] t_sample;
   logic [31:0] t_start;
   logic [31:0] free_ns;
   logic free_tick;
   logic out_start;
   logic in_start;
   logic out_dc;
   logic in_dc;
   logic measuring;
   logic measure_prev;
   logic [31:0] maxv [M_NUM];
   logic [31:0] cand [M_NUM];
   logic [M_NUM-1:0] cand_ok;
   scs_mon_t out_mon;
   scs_mon_t in_mon;
   logic [IRQ_W-1:0] irq_set;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_have;
   logic w_have;
   logic wr_go;
   logic [31:0] rd_word;
   logic rd_err;
   logic wr_err;

   if (STEP_NS < 1)
      $error("clock step must be positive");

   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (s[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      return r;
   endfunction

   // sync pins cross in through two flops before edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s0_sync <= 2'b00;
         s1_sync <= 2'b00;
         s0_prev <= 1'b0;
         s1_prev <= 1'b0;
      end
      else
      begin
         s0_sync <= {s0_sync[0], sync0_pin};
         s1_sync <= {s1_sync[0], sync1_pin};
         s0_prev <= s0_sync[1];
         s1_prev <= s1_sync[1];
      end
   end

   assign sync0 = s0_sync[1] && !s0_prev;
   assign sync1 = s1_sync[1] && !s1_prev;

   // local timer period in free run
   always_ff @(posedge aclk)
   begin
      if (!aresetn || free_tick)
         free_ns <= '0;
      else
         free_ns <= free_ns + 32'(STEP_NS);
   end

   assign free_tick = free_ns + 32'(STEP_NS) >= out_cycle_period;

   always_comb
   begin
      unique case (out_sync_select)
         MODE_FREE: out_start = free_tick;
         MODE_SM: out_start = evt.sm_out;
         MODE_SYNC0: out_start = sync0;
         MODE_SYNC1: out_start = sync1;
         default: out_start = 1'b0;
      endcase
   end

   always_comb
   begin
      unique case (in_sync_select)
         MODE_FREE: in_start = free_tick;
         MODE_SM: in_start = evt.sm_in;
         MODE_SYNC0: in_start = sync0;
         MODE_SYNC1: in_start = sync1;
         MODE_SM_OUT: in_start = evt.sm_out;
         default: in_start = 1'b0;
      endcase
   end

   assign out_dc = out_sync_select == MODE_SYNC0 || out_sync_select == MODE_SYNC1;
   assign in_dc = in_sync_select == MODE_SYNC0 || in_sync_select == MODE_SYNC1;

   // ns time stamps; wrap is harmless since only differences are used
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         now_ns <= '0;
         t_sync0 <= '0;
         t_sync1 <= '0;
         t_sample <= '0;
         t_start <= '0;
      end
      else
      begin
         now_ns <= now_ns + 32'(STEP_NS);
         if (sync0)
            t_sync0 <= now_ns;
         if (sync1)
            t_sync1 <= now_ns;
         if (evt.in_sample)
            t_sample <= now_ns;
         if (out_start)
            t_start <= now_ns;
      end
   end

   always_comb
   begin
      cand[M_OUT_SHIFT] = now_ns - t_sync0;
      cand_ok[M_OUT_SHIFT] = evt.out_drive && out_dc;
      cand[M_MIN_CYCLE] = now_ns - t_start;
      cand_ok[M_MIN_CYCLE] = out_start;
      cand[M_OUT_CALC] = now_ns - t_sync0;
      cand_ok[M_OUT_CALC] = sync1 && out_dc;
      cand[M_OUT_MAX_DELAY] = now_ns - t_sync1;
      cand_ok[M_OUT_MAX_DELAY] = evt.out_drive && out_dc;
      cand[M_IN_SHIFT] = now_ns - t_sync0;
      cand_ok[M_IN_SHIFT] = evt.in_sample && in_dc;
      cand[M_IN_CALC] = now_ns - t_sample;
      cand_ok[M_IN_CALC] = evt.in_ready && in_dc;
      cand[M_IN_MAX_DELAY] = now_ns - t_sync1;
      cand_ok[M_IN_MAX_DELAY] = evt.in_sample && in_dc;
   end

   // either command word set to one runs the measurement
   assign measuring = out_measure_command == CMD_START || in_measure_command == CMD_START;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         measure_prev <= 1'b0;
      else
         measure_prev <= measuring;
   end

   for (genvar g = 0; g < M_NUM; g++)
   begin : g_max
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            maxv[g] <= (g == M_MIN_CYCLE) ? MIN_CYCLE_RST : TIME_RST;
         else if (measuring && !measure_prev)
            maxv[g] <= (g == M_MIN_CYCLE) ? MIN_CYCLE_RST : TIME_RST;
         else if (measuring && cand_ok[g] && cand[g] > maxv[g])
            maxv[g] <= cand[g];
      end
   end

   scs_side_mon #(.STEP_NS(STEP_NS)) u_out_mon (
      .aclk(aclk),
      .aresetn(aresetn),
      .dc_mode(out_dc),
      .op_state(op_state),
      .cycle_period(out_cycle_period),
      .cycle_start(out_start),
      .sm_event(evt.sm_out),
      .sync0(sync0),
      .sync1(sync1),
      .done(evt.out_drive),
      .mon(out_mon)
   );

   scs_side_mon #(.STEP_NS(STEP_NS)) u_in_mon (
      .aclk(aclk),
      .aresetn(aresetn),
      .dc_mode(in_dc),
      .op_state(op_state),
      .cycle_period(in_cycle_period),
      .cycle_start(in_start),
      .sm_event(evt.sm_in),
      .sync0(sync0),
      .sync1(sync1),
      .done(evt.in_sample),
      .mon(in_mon)
   );

   assign irq_set = {in_mon.irq, out_mon.irq};

   // write channel: address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         aw_have <= 1'b0;
         aw_addr <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         s_axi_awready <= 1'b0;
         aw_have <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      else if (wr_go)
         aw_have <= 1'b0;
      else if (!aw_have && !s_axi_bvalid)
         s_axi_awready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_wready <= 1'b0;
         w_have <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         s_axi_wready <= 1'b0;
         w_have <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
         w_have <= 1'b0;
      else if (!w_have && !s_axi_bvalid)
         s_axi_wready <= 1'b1;
   end

   assign wr_go = aw_have && w_have && !s_axi_bvalid;

   always_comb
   begin
      unique case (aw_addr)
         REG_SYNC_SELECT, REG_CYCLE_PERIOD, REG_COMMAND, REG_IRQ_STATUS, REG_IRQ_MASK,
         SIDE_IN_BASE + REG_SYNC_SELECT, SIDE_IN_BASE + REG_CYCLE_PERIOD,
         SIDE_IN_BASE + REG_COMMAND: wr_err = 1'b0;
         // read-only words accept and ignore writes
         default: wr_err = aw_addr[7] || aw_addr[1:0] != 2'b00 || aw_addr[5:0] > REG_PARAM_COUNT;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_sync_select <= OUT_SYNC_RST;
         in_sync_select <= IN_SYNC_RST;
         out_cycle_period <= CYCLE_RST;
         in_cycle_period <= CYCLE_RST;
         out_measure_command <= CMD_STOP;
         in_measure_command <= CMD_STOP;
         irq_mask <= '0;
      end
      else if (wr_go)
      begin
         unique case (aw_addr)
            REG_SYNC_SELECT: out_sync_select <= 16'(merge({16'h0000, out_sync_select}, w_data,
               w_strb));
            REG_CYCLE_PERIOD: out_cycle_period <= merge(out_cycle_period, w_data, w_strb);
            REG_COMMAND: out_measure_command <= 16'(merge({16'h0000, out_measure_command},
               w_data, w_strb));
            SIDE_IN_BASE + REG_SYNC_SELECT: in_sync_select <= 16'(merge({16'h0000,
               in_sync_select}, w_data, w_strb));
            SIDE_IN_BASE + REG_CYCLE_PERIOD: in_cycle_period <= merge(in_cycle_period, w_data,
               w_strb);
            SIDE_IN_BASE + REG_COMMAND: in_measure_command <= 16'(merge({16'h0000,
               in_measure_command}, w_data, w_strb));
            REG_IRQ_MASK: irq_mask <= w_data[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // sticky status; a set in the clearing cycle survives
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_status <= '0;
      else if (wr_go && aw_addr == REG_IRQ_STATUS && w_strb[0])
         irq_status <= (irq_status & ~w_data[IRQ_W-1:0]) | irq_set;
      else
         irq_status <= irq_status | irq_set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   // read decode; one side word layout serves both halves
   always_comb
   begin
      logic in_side;
      scs_mon_t m;
      in_side = s_axi_araddr[6];
      m = in_side ? in_mon : out_mon;
      rd_err = 1'b0;
      rd_word = '0;
      if (s_axi_araddr == REG_IRQ_STATUS)
         rd_word = {24'h000000, irq_status};
      else if (s_axi_araddr == REG_IRQ_MASK)
         rd_word = {24'h000000, irq_mask};
      else if (s_axi_araddr[7])
         rd_err = 1'b1;
      else
      begin
         unique case ({2'b00, s_axi_araddr[5:0]})
            REG_SYNC_SELECT: rd_word = {16'h0000, in_side ? in_sync_select : out_sync_select};
            REG_CYCLE_PERIOD: rd_word = in_side ? in_cycle_period : out_cycle_period;
            REG_SHIFT: rd_word = in_side ? maxv[M_IN_SHIFT] : maxv[M_OUT_SHIFT];
            REG_SUPPORTED: rd_word = {16'h0000, SUPPORTED_MODES};
            REG_MIN_CYCLE: rd_word = maxv[M_MIN_CYCLE];
            REG_CALC_COPY: rd_word = in_side ? maxv[M_IN_CALC] : maxv[M_OUT_CALC];
            REG_MIN_DELAY: rd_word = TIME_RST;
            REG_COMMAND: rd_word = {16'h0000, in_side ? in_measure_command :
               out_measure_command};
            REG_MAX_DELAY: rd_word = in_side ? maxv[M_IN_MAX_DELAY] : maxv[M_OUT_MAX_DELAY];
            REG_MISSED: rd_word = {16'h0000, m.missed};
            REG_OVERRUN: rd_word = {16'h0000, m.overrun};
            REG_SHORT_GAP: rd_word = {16'h0000, m.short_gap};
            REG_FAULT: rd_word = {31'h00000000, m.fault};
            REG_PARAM_COUNT: rd_word = {24'h000000, PARAM_COUNT};
            default: rd_err = 1'b1;
         endcase
      end
   end

   // read channel: data one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_err ? 32'h00000000 : rd_word;
         s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end
endmodule

// *** hw/scs_pkg.sv ***
// shared constants and carrier types for the sync cycle supervision block
package scs_pkg;
   // register map, byte addresses; the input side sits at base plus offset
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_SYNC_SELECT = 8'h00;
   localparam logic [7:0] REG_CYCLE_PERIOD = 8'h04;
   localparam logic [7:0] REG_SHIFT = 8'h08;
   localparam logic [7:0] REG_SUPPORTED = 8'h0C;
   localparam logic [7:0] REG_MIN_CYCLE = 8'h10;
   localparam logic [7:0] REG_CALC_COPY = 8'h14;
   localparam logic [7:0] REG_MIN_DELAY = 8'h18;
   localparam logic [7:0] REG_COMMAND = 8'h1C;
   localparam logic [7:0] REG_MAX_DELAY = 8'h20;
   localparam logic [7:0] REG_MISSED = 8'h24;
   localparam logic [7:0] REG_OVERRUN = 8'h28;
   localparam logic [7:0] REG_SHORT_GAP = 8'h2C;
   localparam logic [7:0] REG_FAULT = 8'h30;
   localparam logic [7:0] REG_PARAM_COUNT = 8'h34;
   localparam logic [7:0] SIDE_IN_BASE = 8'h40;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h80;
   localparam logic [7:0] REG_IRQ_MASK = 8'h84;
   // reset values
   localparam logic [15:0] OUT_SYNC_RST = 16'h0001;
   localparam logic [15:0] IN_SYNC_RST = 16'h0022;
   localparam logic [31:0] CYCLE_RST = 32'h000F4240;
   localparam logic [31:0] MIN_CYCLE_RST = 32'h000186A0;
   localparam logic [31:0] TIME_RST = 32'h00000000;
   localparam logic [15:0] SUPPORTED_MODES = 16'hC807;
   localparam logic [7:0] PARAM_COUNT = 8'h20;
   localparam logic [15:0] CMD_STOP = 16'h0000;
   localparam logic [15:0] CMD_START = 16'h0001;
   // sync modes
   localparam logic [15:0] MODE_FREE = 16'h0000;
   localparam logic [15:0] MODE_SM = 16'h0001;
   localparam logic [15:0] MODE_SYNC0 = 16'h0002;
   localparam logic [15:0] MODE_SYNC1 = 16'h0003;
   localparam logic [15:0] MODE_SM_OUT = 16'h0022;
   // timing
   localparam int CLK_FREQ_MHZ = 125;
   localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
   // interrupt bits, input side shifted up by IRQ_IN_OFS
   localparam int IRQ_W = 8;
   localparam int IRQ_MISSED = 0;
   localparam int IRQ_OVERRUN = 1;
   localparam int IRQ_SHORT_GAP = 2;
   localparam int IRQ_FAULT = 3;
   localparam int IRQ_IN_OFS = 4;
   // captured maxima
   localparam int M_OUT_SHIFT = 0;
   localparam int M_MIN_CYCLE = 1;
   localparam int M_OUT_CALC = 2;
   localparam int M_OUT_MAX_DELAY = 3;
   localparam int M_IN_SHIFT = 4;
   localparam int M_IN_CALC = 5;
   localparam int M_IN_MAX_DELAY = 6;
   localparam int M_NUM = 7;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // one-cycle process data events from the local logic
   typedef struct packed {
      logic sm_out;
      logic sm_in;
      logic out_drive;
      logic in_sample;
      logic in_ready;
   } scs_evt_t;

   // one side's supervision results
   typedef struct packed {
      logic [15:0] missed;
      logic [15:0] overrun;
      logic [15:0] short_gap;
      logic fault;
      logic [3:0] irq;
   } scs_mon_t;
endpackage

// *** hw/scs_sat_count.sv ***
// saturating event counter
`timescale 1ns/1ns
module scs_sat_count #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // event and count
   input wire logic inc,
   output logic [W-1:0] count
);
   if (W < 1)
      $error("counter width must be positive");

   // holding at all ones keeps a large count from reading small
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count <= '0;
      else if (inc && count != {W{1'b1}})
         count <= count + 1'b1;
   end
endmodule

// *** hw/scs_side_mon.sv ***
// per-side supervision: missed events, overruns, short gaps, sync fault
`timescale 1ns/1ns
module scs_side_mon
   import scs_pkg::*;
#(
   parameter int STEP_NS = CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // conditions
   input wire logic dc_mode,
   input wire logic op_state,
   input wire logic [31:0] cycle_period,
   // events
   input wire logic cycle_start,
   input wire logic sm_event,
   input wire logic sync0,
   input wire logic sync1,
   input wire logic done,
   // results
   output scs_pkg::scs_mon_t mon
);
   logic seen_sm;
   logic busy;
   logic late_flagged;
   logic waiting;
   logic late;
   logic [31:0] elapsed;
   logic miss_ev;
   logic over_ev;
   logic gap_ev;
   logic fault_q;
   logic [3:0] irq_c;
   logic [15:0] missed_c;
   logic [15:0] overrun_c;
   logic [15:0] gap_c;

   if (STEP_NS < 1)
      $error("clock step must be positive");

   assign miss_ev = dc_mode && op_state && sync0 && !seen_sm && !sm_event;
   assign over_ev = op_state && busy && ((cycle_start && !done)
      || (!late_flagged && elapsed >= cycle_period));
   assign gap_ev = dc_mode && sync1 && waiting && !done;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || sync0)
         seen_sm <= 1'b0;
      else if (sm_event)
         seen_sm <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         busy <= 1'b0;
         elapsed <= '0;
         late_flagged <= 1'b0;
      end
      else if (cycle_start)
      begin
         busy <= 1'b1;
         elapsed <= '0;
         late_flagged <= 1'b0;
      end
      else if (done)
         busy <= 1'b0;
      else if (busy)
      begin
         elapsed <= elapsed + 32'(STEP_NS);
         if (over_ev)
            late_flagged <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         waiting <= 1'b0;
         late <= 1'b0;
         fault_q <= 1'b0;
      end
      else if (sync0)
      begin
         waiting <= 1'b1;
         late <= 1'b0;
         fault_q <= dc_mode && late;
      end
      else
      begin
         if (done)
            waiting <= 1'b0;
         if (gap_ev)
            late <= 1'b1;
      end
   end

   assign irq_c = {dc_mode && sync0 && late, gap_ev, over_ev, miss_ev};
   // one driver for the whole result word
   assign mon = {missed_c, overrun_c, gap_c, fault_q, irq_c};

   scs_sat_count #(.W(16)) u_missed (
      .aclk(aclk), .aresetn(aresetn), .inc(miss_ev), .count(missed_c));
   scs_sat_count #(.W(16)) u_overrun (
      .aclk(aclk), .aresetn(aresetn), .inc(over_ev), .count(overrun_c));
   scs_sat_count #(.W(16)) u_gap (
      .aclk(aclk), .aresetn(aresetn), .inc(gap_ev), .count(gap_c));
endmodule

// *** dv/scs_sync_checker.sv ***
// bus and register checks on the supervision block ports
`timescale 1ns/1ns
module scs_sync_checker
   import scs_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write side
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read side
   input wire logic [scs_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic ar_take;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped early");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped early");
   property p_wresp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wresp: assert property (p_wresp) else $error("write answer late");
   property p_rresp;
      ar_take |=> s_axi_rvalid;
   endproperty
   a_rresp: assert property (p_rresp) else $error("read answer late");
   property p_busy;
      s_axi_rvalid || s_axi_bvalid |-> !s_axi_arready || !s_axi_awready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready while answer pending");
   property p_sup;
      ar_take && s_axi_araddr == 8'h0C |=> s_axi_rdata == 32'h0000C807;
   endproperty
   a_sup: assert property (p_sup) else $error("supported word wrong");
   property p_pcnt;
      ar_take && s_axi_araddr == 8'h34 |=> s_axi_rdata == 32'h00000020;
   endproperty
   a_pcnt: assert property (p_pcnt) else $error("parameter count wrong");
   property p_unmap;
      ar_take && s_axi_araddr == 8'h38 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read answered");
endmodule
bind scs_sync_supervision scs_sync_checker chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** dv/scs_evt_src.sv ***
// sync pin and process data event source for the far side
`timescale 1ns/1ns
module scs_evt_src
   import scs_pkg::*;
(
   // clock
   input wire logic aclk,
   // pins and events
   output logic sync0_pin,
   output logic sync1_pin,
   output scs_pkg::scs_evt_t evt
);
   initial
   begin
      sync0_pin = 1'b0;
      sync1_pin = 1'b0;
      evt = '0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // pins held 4 cycles, above the 2-cycle minimum
   task automatic cycle(input bit sm, input bit s1, input bit drv);
      evt.sm_out <= sm;
      hold(1);
      evt.sm_out <= 1'b0;
      sync0_pin <= 1'b1;
      hold(4);
      sync0_pin <= 1'b0;
      sync1_pin <= s1;
      hold(4);
      sync1_pin <= 1'b0;
      hold(4);
      evt.out_drive <= drv;
      evt.in_sample <= drv;
      evt.in_ready <= drv;
      hold(1);
      evt <= '0;
      hold(8);
   endtask
endmodule

// *** dv/test_sync_cycle_supervision.sv ***
// self-checking bench for the sync supervision register bank
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module test_sync_cycle_supervision;
   import scs_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bvalid, bready = 0, op_state = 0;
   logic awready, wready, arready, rvalid, arvalid = 0, rready = 0, irq, s0, s1;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0] bresp, rresp, r;
   scs_evt_t evt;
   int n_errors = 0, compares = 0, cyc = 0;
   logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h1C, 8'h30, 8'h34, 8'h40, 8'h44, 8'h50};
   logic [31:0] re [10] = '{32'h1, 32'hF4240, 32'hC807, 32'h186A0, 32'h0, 32'h0, 32'h20,
      32'h22, 32'hF4240, 32'h186A0};
   logic [15:0] modes [5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h22};
   always #4 aclk = ~aclk;
   scs_evt_src src (.aclk(aclk), .sync0_pin(s0), .sync1_pin(s1), .evt(evt));
   scs_sync_supervision DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sync0_pin(s0),
      .sync1_pin(s1), .evt(evt), .op_state(op_state), .irq(irq));
   task automatic final_report;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] v);
      rd(a);
      `CHK(d, v)
   endtask
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         final_report();
      end
   end
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 10; i++)
         rc(ra[i], re[i]);
      rd(8'h38);
      `CHK(r, RESP_SLVERR)
      wr(8'h3C, 32'h1);
      `CHK(r, RESP_SLVERR)
      wr(8'h0C, 32'h0);
      rc(8'h0C, 32'h0000C807);
      for (int i = 0; i < 5; i++)
      begin
         wr(8'h40, {16'h0, modes[i]});
         rc(8'h40, {16'h0, modes[i]});
         wr(8'h00, {16'h0, modes[i & 3]});
         rc(8'h00, {16'h0, modes[i & 3]});
      end
      wr(8'h44, 32'h0007A120);
      rc(8'h44, 32'h0007A120);
      wr(8'h00, 32'h2);
      op_state <= 1'b1;
      src.cycle(1, 0, 1);
      src.cycle(1, 1, 1);
      rc(8'h2C, 32'h1);
      src.cycle(1, 0, 1);
      rc(8'h30, 32'h1);
      src.cycle(0, 0, 1);
      rc(8'h24, 32'h1);
      src.cycle(1, 0, 0);
      src.cycle(1, 0, 1);
      rc(8'h28, 32'h1);
      rd(8'h80);
      `CHK(d[3:0], 4'hF)
      `CHK(irq, 1'b0)
      wr(8'h84, 32'h1);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(8'h80, 32'hFF);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b0)
      wr(8'h1C, 32'h1);
      rc(8'h1C, 32'h1);
      src.cycle(1, 1, 1);
      wr(8'h1C, 32'h0);
      rc(8'h1C, 32'h0);
      rc(8'h14, 32'h20);
      rc(8'h08, 32'h50);
      rd(8'h20);
      `CHK(d != 32'h0, 1'b1)
      wr(8'h1C, 32'h1);
      rc(8'h20, 32'h0);
      final_report();
   end
endmodule
